/* design/lsd_regs.vh */
// Constants for the level switch with delay and hysteresis
`ifndef LSD_REGS_VH
`define LSD_REGS_VH
`define LSD_CLK_HZ        32'h017D_7840
`define LSD_TICK_MS       32'h0000_0064
`define LSD_MS_PER_S      32'h0000_03E8
`define LSD_UP_DEF        7'h4B
`define LSD_LO_DEF        7'h19
`define LSD_PCT_MAX       7'h64
`define LSD_DLY_DEF       10'h000
`define LSD_DLY_MAX       10'h3E8
`define LSD_DLY_STEP      10'h001
`define LSD_REP_FIRST_MS  32'h0000_03E8
`define LSD_REP_NEXT_MS   32'h0000_00C8
`define LSD_SEL_DLY_UP    2'h0
`define LSD_SEL_DLY_LO    2'h1
`define LSD_SEL_TH_UP     2'h2
`define LSD_SEL_TH_LO     2'h3
`define LSD_PROF_FSH      2'h0
`define LSD_PROF_FSL      2'h1
`define LSD_PROF_FPM      2'h2
`endif

/* design/lsd_level_switch.v */
// Level switch: threshold hysteresis, qualifying delays, button settings
`timescale 1ns/1ps
`include "lsd_regs.vh"
module lsd_level_switch #(
  parameter TICK_CYC = (`LSD_CLK_HZ / `LSD_MS_PER_S) * `LSD_TICK_MS,
  parameter FIRST_TICKS = `LSD_REP_FIRST_MS / `LSD_TICK_MS,
  parameter NEXT_TICKS  = `LSD_REP_NEXT_MS / `LSD_TICK_MS
) (
  // Clock and reset
  input  wire       CLK,
  input  wire       NRST,
  // Measured level in percent of range
  input  wire [6:0] LEVEL_PCT,
  // Front-panel buttons, asynchronous; setting select
  input  wire       BTN_UP,
  input  wire       BTN_DOWN,
  input  wire [1:0] SETTING_SEL,
  // Loop-current configuration
  input  wire [1:0] PROFILE,
  input  wire       ANALOG_MODE,
  input  wire       POLARITY_HIGH,
  // Status and settings
  output reg        COVERED,
  output reg  [9:0] UP_DELAY,
  output reg  [9:0] LO_DELAY,
  output reg  [6:0] UP_THRESH,
  output reg  [6:0] LO_THRESH,
  output reg        SHOW_DASHES,
  // Loop stage: 1 = 20 mA, 0 = 4 mA; proportional path enable
  output reg        LOOP_HIGH,
  output reg        PROP_EN
);

  // Tick divider
  reg  [31:0] tick_cnt_reg;
  reg         tick_reg;
  // Button synchronisers
  reg  [1:0]  up_sync_reg;
  reg  [1:0]  dn_sync_reg;
  // Qualifying timers
  reg  [9:0]  act_cnt_reg;
  reg  [9:0]  deact_cnt_reg;
  // Button hold and edge state
  reg  [4:0]  hold_cnt_reg;
  reg         both_done_reg;
  reg         prev_up_reg;
  reg         prev_dn_reg;
  wire        up = up_sync_reg[1];
  wire        dn = dn_sync_reg[1];
  wire        free_programming_profile = (PROFILE == `LSD_PROF_FPM);
  wire        analog = free_programming_profile & ANALOG_MODE;
  wire        edit_ok = ~analog;
  wire        above = (LEVEL_PCT > UP_THRESH);
  wire        below = (LEVEL_PCT < LO_THRESH);
  wire        single = up ^ dn;
  wire        first_press = (up & ~prev_up_reg) | (dn & ~prev_dn_reg);
  // Repeat fires on the tick that completes the hold, so the first repeat
  // lands FIRST_TICKS ticks after the press; FIRST_TICKS must not be zero
  wire        rep_armed = (hold_cnt_reg >= FIRST_TICKS[4:0] - 5'h01);
  wire        rep_step = tick_reg & rep_armed;
  wire        step = single & (first_press | rep_step) & ~both_done_reg;
  // Second button joining restarts the hold count for the toggle
  wire        both_rise = up & dn & ((up & ~prev_up_reg) | (dn & ~prev_dn_reg));
  // Toggle fires once per hold; both_done blocks it until release
  wire        toggle_now = up & dn & (hold_cnt_reg >= FIRST_TICKS[4:0]) & ~both_done_reg;
  wire        dly_sel = (SETTING_SEL == `LSD_SEL_DLY_UP) | (SETTING_SEL == `LSD_SEL_DLY_LO);

  // Clamped steps: a press past either end is ignored
  function [9:0] dly_step;
    input [9:0] v;
    input       inc;
    begin
      if (inc)
        dly_step = (v >= `LSD_DLY_MAX) ? `LSD_DLY_MAX : v + `LSD_DLY_STEP;
      else
        dly_step = (v == 10'h000) ? 10'h000 : v - `LSD_DLY_STEP;
    end
  endfunction

  function [6:0] pct_step;
    input [6:0] v;
    input       inc;
    begin
      if (inc)
        pct_step = (v >= `LSD_PCT_MAX) ? `LSD_PCT_MAX : v + 7'h01;
      else
        pct_step = (v == 7'h00) ? 7'h00 : v - 7'h01;
    end
  endfunction

  // Tenth-second tick
  // Free-running, so a delay may qualify up to one tick early
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg >= TICK_CYC - 32'h0000_0001) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick_reg     <= 1'b0;
    end
  end

  // Button synchronisers; stage 0 feeds stage 1 only
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      up_sync_reg <= 2'h0;
      dn_sync_reg <= 2'h0;
      prev_up_reg <= 1'b0;
      prev_dn_reg <= 1'b0;
    end else begin
      up_sync_reg <= {up_sync_reg[0], BTN_UP};
      dn_sync_reg <= {dn_sync_reg[0], BTN_DOWN};
      prev_up_reg <= up;
      prev_dn_reg <= dn;
    end
  end

  // Hold timing: repeat delay and both-button hold
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      hold_cnt_reg  <= 5'h00;
      both_done_reg <= 1'b0;
    end else if (~up & ~dn) begin
      hold_cnt_reg  <= 5'h00;
      both_done_reg <= 1'b0;
    end else if (both_rise) begin
      hold_cnt_reg <= 5'h00;
    end else if (rep_step & single) begin
      hold_cnt_reg <= FIRST_TICKS[4:0] - NEXT_TICKS[4:0];
    end else if (tick_reg & (hold_cnt_reg < FIRST_TICKS[4:0])) begin
      hold_cnt_reg <= hold_cnt_reg + 5'h01;
    end else if (toggle_now) begin
      // Hold count parks at FIRST_TICKS while both stay down
      both_done_reg <= 1'b1;
    end
  end

  // Settings, editable only in two-state mode
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      UP_DELAY  <= `LSD_DLY_DEF;
      LO_DELAY  <= `LSD_DLY_DEF;
      UP_THRESH <= `LSD_UP_DEF;
      LO_THRESH <= `LSD_LO_DEF;
    end else if (edit_ok) begin
      // Any value but zero toggles to zero; zero toggles to the maximum
      if (toggle_now & dly_sel) begin
        if (SETTING_SEL == `LSD_SEL_DLY_UP)
          UP_DELAY <= (UP_DELAY == 10'h000) ? `LSD_DLY_MAX : 10'h000;
        else
          LO_DELAY <= (LO_DELAY == 10'h000) ? `LSD_DLY_MAX : 10'h000;
      end else if (step) begin
        case (SETTING_SEL)
          `LSD_SEL_DLY_UP: UP_DELAY  <= dly_step(UP_DELAY, up);
          `LSD_SEL_DLY_LO: LO_DELAY  <= dly_step(LO_DELAY, up);
          `LSD_SEL_TH_UP:  UP_THRESH <= pct_step(UP_THRESH, up);
          default:         LO_THRESH <= pct_step(LO_THRESH, up);
        endcase
      end
    end
  end

  // Qualifying timers and covered state
  // Only one timer runs at a time: the covered state picks which
  // Both branches may write COVERED, but never in the same cycle
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      act_cnt_reg   <= 10'h000;
      deact_cnt_reg <= 10'h000;
      COVERED       <= 1'b0;
    end else begin
      if (!above || COVERED) begin
        act_cnt_reg <= 10'h000;
      end else if (act_cnt_reg >= UP_DELAY) begin
        COVERED     <= 1'b1;
        act_cnt_reg <= 10'h000;
      end else if (tick_reg) begin
        act_cnt_reg <= act_cnt_reg + 10'h001;
      end
      if (!below || !COVERED) begin
        deact_cnt_reg <= 10'h000;
      end else if (deact_cnt_reg >= LO_DELAY) begin
        COVERED       <= 1'b0;
        deact_cnt_reg <= 10'h000;
      end else if (tick_reg) begin
        deact_cnt_reg <= deact_cnt_reg + 10'h001;
      end
    end
  end

  // Loop-current stage
  // Fault levels are outside this block; COVERED and polarity alone pick the level
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      LOOP_HIGH   <= 1'b0;
      PROP_EN     <= 1'b0;
      SHOW_DASHES <= 1'b0;
    end else begin
      LOOP_HIGH   <= COVERED ~^ POLARITY_HIGH;
      PROP_EN     <= analog;
      SHOW_DASHES <= analog;
    end
  end

endmodule // lsd_level_switch

/* dv/lsd_level_switch_props.sv */
// Assertions on the level switch ports
`timescale 1ns/1ps
`include "lsd_regs.vh"
module lsd_level_switch_props (
  // Clock and reset
  input wire       CLK,
  input wire       NRST,
  // Design inputs
  input wire [6:0] LEVEL_PCT,
  input wire       BTN_UP,
  input wire       BTN_DOWN,
  input wire [1:0] SETTING_SEL,
  input wire [1:0] PROFILE,
  input wire       ANALOG_MODE,
  input wire       POLARITY_HIGH,
  // Design outputs
  input wire       COVERED,
  input wire [9:0] UP_DELAY,
  input wire [9:0] LO_DELAY,
  input wire [6:0] UP_THRESH,
  input wire [6:0] LO_THRESH,
  input wire       SHOW_DASHES,
  input wire       LOOP_HIGH,
  input wire       PROP_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  chk_loop_level: assert property (
    $past(NRST) && !PROP_EN && !$past(PROP_EN) |->
    LOOP_HIGH == ($past(COVERED) ~^ $past(POLARITY_HIGH))) else $error("loop level");
  chk_cover_above: assert property (
    $rose(COVERED) |-> $past(LEVEL_PCT) > $past(UP_THRESH)) else $error("cover cause");
  chk_uncover_below: assert property (
    $fell(COVERED) |-> $past(LEVEL_PCT) < $past(LO_THRESH)) else $error("uncover cause");
  chk_fast_cover: assert property (
    !COVERED && UP_DELAY == 10'h000 && LEVEL_PCT > UP_THRESH |=> COVERED)
    else $error("no fast cover");
  chk_fast_uncover: assert property (
    COVERED && LO_DELAY == 10'h000 && LEVEL_PCT < LO_THRESH |=> !COVERED)
    else $error("no fast uncover");
  chk_prop_free: assert property (
    PROP_EN |-> $past(PROFILE) == `LSD_PROF_FPM && $past(ANALOG_MODE)) else $error("prop");
  chk_edit_frozen: assert property (
    SHOW_DASHES && $past(SHOW_DASHES) |-> $stable({UP_DELAY, LO_DELAY, UP_THRESH, LO_THRESH}))
    else $error("edit in analog");
  chk_thr_step: assert property (
    $changed(UP_THRESH) |-> UP_THRESH - $past(UP_THRESH) == 7'h01 ||
    $past(UP_THRESH) - UP_THRESH == 7'h01) else $error("threshold step");
  cover property ($rose(COVERED));
  cover property ($fell(COVERED));
  cover property (LO_DELAY == `LSD_DLY_MAX);
endmodule // lsd_level_switch_props
bind lsd_level_switch lsd_level_switch_props u_props (
  .CLK           (CLK),
  .NRST          (NRST),
  .LEVEL_PCT     (LEVEL_PCT),
  .BTN_UP        (BTN_UP),
  .BTN_DOWN      (BTN_DOWN),
  .SETTING_SEL   (SETTING_SEL),
  .PROFILE       (PROFILE),
  .ANALOG_MODE   (ANALOG_MODE),
  .POLARITY_HIGH (POLARITY_HIGH),
  .COVERED       (COVERED),
  .UP_DELAY      (UP_DELAY),
  .LO_DELAY      (LO_DELAY),
  .UP_THRESH     (UP_THRESH),
  .LO_THRESH     (LO_THRESH),
  .SHOW_DASHES   (SHOW_DASHES),
  .LOOP_HIGH     (LOOP_HIGH),
  .PROP_EN       (PROP_EN)
);

/* dv/lsd_panel_model.sv */
// Front-panel push-button model
`timescale 1ns/1ps
module lsd_panel_model (
  input  wire  CLK,
  output logic BTN_UP = 1'b0,
  output logic BTN_DOWN = 1'b0
);
  // Release gap lets the sync stages see both buttons up
  task automatic push(input logic up, dn, input int hold);
    @(posedge CLK);
    BTN_UP <= up;
    BTN_DOWN <= dn;
    repeat (hold) @(posedge CLK);
    BTN_UP <= 1'b0;
    BTN_DOWN <= 1'b0;
    repeat (6) @(posedge CLK);
  endtask
endmodule // lsd_panel_model

/* dv/lsd_level_switch_test.sv */
// Self-checking bench for the level switch
`timescale 1ns/1ps
`include "lsd_regs.vh"
`define CHK(nm, got, exp) begin #1; n_checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("MISMATCH %s exp %0h got %0h", nm, exp, got); end end
module lsd_level_switch_test;
  logic       CLK = 0, NRST = 0, ANALOG_MODE = 0, POLARITY_HIGH = 1;
  logic [6:0] LEVEL_PCT = 7'h32;
  logic [1:0] SETTING_SEL = 2'h0, PROFILE = 2'h0;
  wire        BTN_UP, BTN_DOWN, COVERED, SHOW_DASHES, LOOP_HIGH, PROP_EN;
  wire  [9:0] UP_DELAY, LO_DELAY;
  wire  [6:0] UP_THRESH, LO_THRESH;
  int         n_fail = 0, n_checks = 0, cyc = 0;
  initial forever #20 CLK = ~CLK;
  lsd_panel_model u_pan (.CLK(CLK), .BTN_UP(BTN_UP), .BTN_DOWN(BTN_DOWN));
  // Short tick keeps the delay scenarios to a few hundred cycles
  lsd_level_switch #(.TICK_CYC(10)) u_dut (
    .CLK           (CLK),
    .NRST          (NRST),
    .LEVEL_PCT     (LEVEL_PCT),
    .BTN_UP        (BTN_UP),
    .BTN_DOWN      (BTN_DOWN),
    .SETTING_SEL   (SETTING_SEL),
    .PROFILE       (PROFILE),
    .ANALOG_MODE   (ANALOG_MODE),
    .POLARITY_HIGH (POLARITY_HIGH),
    .COVERED       (COVERED),
    .UP_DELAY      (UP_DELAY),
    .LO_DELAY      (LO_DELAY),
    .UP_THRESH     (UP_THRESH),
    .LO_THRESH     (LO_THRESH),
    .SHOW_DASHES   (SHOW_DASHES),
    .LOOP_HIGH     (LOOP_HIGH),
    .PROP_EN       (PROP_EN)
  );
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic tap(input logic [1:0] sel, input logic u, d, input int n, hold);
    @(posedge CLK);
    SETTING_SEL <= sel;
    repeat (n) u_pan.push(u, d, hold);
  endtask
  // Breaks the condition once, then expects qualification only after a full restart
  task automatic qual(input logic [6:0] go, brk, input logic exp, input int n);
    int k = 0;
    @(posedge CLK);
    LEVEL_PCT <= go;
    repeat (n * 10 - 15) @(posedge CLK);
    LEVEL_PCT <= brk;
    @(posedge CLK);
    LEVEL_PCT <= go;
    repeat (n * 10 - 13) @(posedge CLK);
    `CHK("early", COVERED, !exp)
    while (COVERED !== exp && k < 40) begin
      @(posedge CLK);
      #1;
      k++;
    end
    `CHK("qual", COVERED, exp)
    @(posedge CLK);
  endtask
  initial begin
    void'($urandom(97));
    repeat (10) @(posedge CLK);
    NRST <= 1;
    `CHK("up_thr", UP_THRESH, `LSD_UP_DEF)
    `CHK("lo_thr", LO_THRESH, `LSD_LO_DEF)
    `CHK("dly", {UP_DELAY, LO_DELAY}, 20'h0_0000)
    @(posedge CLK);
    LEVEL_PCT <= `LSD_UP_DEF;
    repeat (4) @(posedge CLK);
    `CHK("at_upper", COVERED, 1'b0)
    @(posedge CLK);
    LEVEL_PCT <= `LSD_PCT_MAX;
    repeat (3) @(posedge CLK);
    `CHK("fast_cov", COVERED, 1'b1)
    @(posedge CLK);
    LEVEL_PCT <= 7'h00;
    repeat (3) @(posedge CLK);
    `CHK("fast_unc", COVERED, 1'b0)
    tap(2'h0, 1, 0, 5, 5);
    tap(2'h0, 0, 1, 1, 5);
    `CHK("up_dly", UP_DELAY, 10'h004)
    tap(2'h1, 1, 0, 3, 5);
    repeat (3) begin
      @(posedge CLK);
      POLARITY_HIGH <= 1'($urandom);
      qual(7'h4C + 7'($urandom % 25), `LSD_UP_DEF, 1'b1, 4);
      `CHK("loop_cov", LOOP_HIGH, POLARITY_HIGH)
      qual(7'($urandom % 25), `LSD_LO_DEF, 1'b0, 3);
      `CHK("loop_unc", LOOP_HIGH, !POLARITY_HIGH)
    end
    // Lower delay stands at 3 here: a held pair drops it to zero, the next one to max
    tap(2'h1, 1, 1, 1, 130);
    `CHK("tog_min", LO_DELAY, 10'h000)
    tap(2'h1, 1, 1, 1, 130);
    `CHK("tog_max", LO_DELAY, `LSD_DLY_MAX)
    tap(2'h2, 0, 1, 1, 5);
    `CHK("thr_dec", UP_THRESH, 7'h4A)
    tap(2'h3, 1, 0, 1, 150);
    `CHK("repeat", LO_THRESH > 7'h1A, 1'b1)
    for (int p = 0; p < 3; p++) begin
      @(posedge CLK);
      PROFILE <= 2'(p);
      ANALOG_MODE <= 1'b1;
      tap(2'h2, 1, 0, 1, 5);
      `CHK("prop", PROP_EN, p == 2)
      `CHK("dash", SHOW_DASHES, p == 2)
    end
    `CHK("frozen", UP_THRESH, 7'h4C)
    summarize();
  end
endmodule // lsd_level_switch_test
